// [hw/fpm_dram_regs.vh]
// constants for the fast-page dram page controller
// assumes inclusion by bare name from the design files under hw/
`ifndef FPM_DRAM_REGS_VH
`define FPM_DRAM_REGS_VH
// ==================================================
// size codes
`define SIZE_LONG 2'h0
`define SIZE_BYTE 2'h1
`define SIZE_WORD 2'h2
// ==================================================
// address field positions
`define ADDR_HI 27
`define ADDR_LO 9
`define ROW_BITS 19
// ==================================================
// timing: clock period and ras precharge in ns, counts in clocks
`define CLK_PERIOD_NS 10
`define RAS_PRE_NS 10
`define RAS_PRE_CYC ((`RAS_PRE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HIT_GAP_CYC 2
`define CAS_PRE_DEFAULT 4'h1
`endif

// [hw/page_tracker.v]
// per-bank open-page record with row comparison
// assumes requests and updates come from the same ref_clk domain
`timescale 1ns/1ps
`include "fpm_dram_regs.vh"
module page_tracker #(
  parameter BANKS = 2,
  parameter ROW_W = `ROW_BITS
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // lookup
  input wire [0:0] look_bank,
  input wire [ROW_W-1:0] look_row,
  output wire look_open,
  output wire look_hit,
  output wire any_open,
  // update
  input wire open_set,
  input wire [0:0] set_bank,
  input wire [ROW_W-1:0] set_row,
  input wire close_all
);
  reg [BANKS-1:0] open_reg;
  reg [ROW_W-1:0] row_mem [0:BANKS-1];
  genvar b;
  generate
    for (b = 0; b < BANKS; b = b + 1) begin : g_bank
      always @(posedge ref_clk) begin
        if (rst || close_all) begin
          open_reg[b] <= 1'b0;
        end else if (open_set && set_bank == b) begin
          open_reg[b] <= 1'b1;
          row_mem[b] <= set_row;
        end
      end
    end
  endgenerate
  assign look_open = open_reg[look_bank];
  assign look_hit = look_open && (row_mem[look_bank] == look_row);
  assign any_open = |open_reg;
endmodule

// [hw/fpm_page_ctrl.v]
// fast-page-mode dram page controller: sequencing, miss handling,
// and page close on loss of bus mastership.
// assumes core request fields held stable until ack; bus_grant_n and
// dram data arrive from pins; other inputs from ref_clk logic.
// half-clock events use a falling-edge strobe register.
// Contract
// - new-page write: row, write low, size, start
// - row strobe half clock after start
// - clock two: start off, column, data high
// - 16-bit port: low two column strobes
// - ack in third clock, completes next edge
// - fourth clock: ack, cas off; ras held
// - page hit two clocks after end, column
// - page hit then follows new-page sequence
// - same-bank row miss waits ras precharge
// - other bank starts without precharge delay
// - fastest miss: one precharge plus three
// - byte read: write high, cas0, top lane
// - read data captured edge after ack
// - miss: ras off next cycle, then reopen
// - page-miss writes time like reads
// - losing mastership precharges open page
// - dram transfer active: bd held till done
// - non-dram active: precharge next cycle
// - idle: release, bd off, ras off
// - lock bit set keeps mastership, page
// - external master uses burst page behaviour
// - burst page closes row after burst
// - page hit waits cas precharge time
`timescale 1ns/1ps
`include "fpm_dram_regs.vh"
module fpm_page_ctrl #(
  parameter ROW_W = `ROW_BITS,
  parameter CAS_PRE_W = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // core request path
  input wire req_valid,
  input wire req_write,
  input wire req_ext_master,
  input wire req_bank,
  input wire [ROW_W-1:0] req_row,
  input wire [ROW_W-1:0] req_col,
  input wire [1:0] req_size,
  input wire [1:0] req_port,
  input wire [31:0] req_wdata,
  output wire req_ready,
  output reg [31:0] rd_data,
  output reg rd_valid,
  output wire int_ack,
  // configuration
  input wire bus_lock_bit,
  input wire [CAS_PRE_W-1:0] cas_pre_cycles,
  // non-dram bus activity
  input wire nondram_busy,
  // bus arbitration
  input wire bus_grant_n,
  output wire bus_driven_n,
  // dram pins
  output reg [`ADDR_HI:`ADDR_LO] addr_out,
  output wire addr_oe,
  output reg mem_write_n,
  output reg [1:0] transfer_size_code,
  output reg transfer_start_n,
  output wire [1:0] ras_n,
  output wire [3:0] cas_n,
  output reg [31:0] data_out,
  output reg data_oe,
  input wire [31:0] data_in
);
  // ==================================================
  // states
  localparam S_IDLE = 3'h0;
  localparam S_PRE = 3'h1;
  localparam S_T1 = 3'h2;
  localparam S_T2 = 3'h3;
  localparam S_T3 = 3'h4;
  localparam S_T4 = 3'h5;
  localparam S_OFF = 3'h6;
  localparam [CAS_PRE_W-1:0] PRE_LOAD = `RAS_PRE_CYC - 1;
  localparam [CAS_PRE_W-1:0] GAP_LOAD = `HIT_GAP_CYC - 1;

  // ==================================================
  // grant synchroniser (pin)
  reg bg_meta_reg;
  reg bg_sync_reg;
  reg bg_prev_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      bg_meta_reg <= 1'b0;
      bg_sync_reg <= 1'b0;
      bg_prev_reg <= 1'b0;
    end else begin
      bg_meta_reg <= bus_grant_n;
      bg_sync_reg <= bg_meta_reg;
      bg_prev_reg <= bg_sync_reg;
    end
  end
  wire granted = ~bg_sync_reg;
  // read data lanes from pins, two flops before use
  reg [31:0] din_meta_reg;
  reg [31:0] din_sync_reg;
  always @(posedge ref_clk) begin
    din_meta_reg <= data_in;
    din_sync_reg <= din_meta_reg;
  end

  // ==================================================
  // state and datapath registers
  reg [2:0] state_reg, state_next;
  reg ras_hi_reg;  // rising-edge part of ras request
  reg [1:0] ras_bank_reg;
  reg [1:0] ras_fall_reg;
  reg cas_en_reg;
  reg [3:0] cas_mask_reg;
  reg [3:0] cas_fall_reg;
  reg ack_reg;
  reg new_page_reg;
  reg cur_bank_reg;
  reg cur_write_reg;
  reg cur_burst_reg;
  reg [ROW_W-1:0] cur_row_reg;
  reg [ROW_W-1:0] cur_col_reg;
  reg [31:0] cur_wdata_reg;
  reg [1:0] cur_port_reg;
  reg [CAS_PRE_W-1:0] gap_cnt_reg;
  reg [CAS_PRE_W-1:0] pre_cnt_reg;
  reg mastership_reg;
  reg release_pend_reg;
  reg capture_reg;

  wire look_open;
  wire look_hit;
  wire any_open;
  reg open_set;
  reg close_all;

  page_tracker #(.BANKS(2), .ROW_W(ROW_W)) u_track (
    .ref_clk(ref_clk),
    .rst(rst),
    .look_bank(req_bank),
    .look_row(req_row),
    .look_open(look_open),
    .look_hit(look_hit),
    .any_open(any_open),
    .open_set(open_set),
    .set_bank(cur_bank_reg),
    .set_row(cur_row_reg),
    .close_all(close_all)
  );

  // ==================================================
  // mastership: lock bit keeps the bus after grant goes away
  wire lost = ~granted & ~bus_lock_bit;
  wire dram_active = (state_reg != S_IDLE) && (state_reg != S_OFF);
  wire idle_ok = (state_reg == S_IDLE) && mastership_reg;
  wire gap_ok = (gap_cnt_reg == {CAS_PRE_W{1'b0}});
  // a hit needs the gap and the cas precharge count to expire
  wire req_go = req_valid && idle_ok && !lost && gap_ok;
  wire req_miss = look_open && !look_hit;
  assign req_ready = (state_reg == S_T3);
  assign int_ack = ack_reg;
  assign bus_driven_n = ~mastership_reg;
  assign addr_oe = mastership_reg;
  assign ras_n = ~(ras_bank_reg & {2{ras_hi_reg}} & (ras_fall_reg |
    ~({2{new_page_reg}} & (2'h1 << cur_bank_reg))));
  assign cas_n = ~cas_fall_reg;

  // byte lanes: 32-bit port all, 16-bit low two, 8-bit lowest
  function [3:0] cas_for_port;
    input [1:0] port;
    begin
      case (port)
        2'h1: cas_for_port = 4'h1;
        2'h2: cas_for_port = 4'h3;
        default: cas_for_port = 4'hf;
      endcase
    end
  endfunction

  // ==================================================
  // next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (!mastership_reg) begin
          state_next = S_IDLE;
        end else if (lost && !nondram_busy) begin
          state_next = S_OFF;
        end else if (req_go) begin
          state_next = req_miss ? S_PRE : S_T1;
        end
      end
      S_PRE: begin
        if (pre_cnt_reg == {CAS_PRE_W{1'b0}}) begin
          state_next = S_T1;
        end
      end
      S_T1: state_next = S_T2;
      S_T2: state_next = S_T3;
      S_T3: state_next = S_T4;
      S_T4: state_next = S_IDLE;
      S_OFF: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // ==================================================
  // rising-edge sequencing
  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      ras_hi_reg <= 1'b0;
      ras_bank_reg <= 2'h0;
      cas_en_reg <= 1'b0;
      cas_mask_reg <= 4'h0;
      ack_reg <= 1'b0;
      new_page_reg <= 1'b0;
      cur_bank_reg <= 1'b0;
      cur_write_reg <= 1'b0;
      cur_burst_reg <= 1'b0;
      cur_row_reg <= {ROW_W{1'b0}};
      cur_col_reg <= {ROW_W{1'b0}};
      cur_wdata_reg <= 32'h0;
      cur_port_reg <= 2'h0;
      gap_cnt_reg <= {CAS_PRE_W{1'b0}};
      pre_cnt_reg <= {CAS_PRE_W{1'b0}};
      mastership_reg <= 1'b1;
      release_pend_reg <= 1'b0;
      capture_reg <= 1'b0;
      addr_out <= {ROW_W{1'b0}};
      mem_write_n <= 1'b1;
      transfer_size_code <= `SIZE_LONG;
      transfer_start_n <= 1'b1;
      data_out <= 32'h0;
      data_oe <= 1'b0;
      rd_data <= 32'h0;
      rd_valid <= 1'b0;
    end else begin
      state_reg <= state_next;
      transfer_start_n <= 1'b1;
      ack_reg <= 1'b0;
      capture_reg <= ack_reg && !cur_write_reg;
      rd_valid <= 1'b0;
      if (capture_reg) begin
        rd_data <= din_sync_reg;
        rd_valid <= 1'b1;
      end
      if (gap_cnt_reg != {CAS_PRE_W{1'b0}}) begin
        gap_cnt_reg <= gap_cnt_reg - 1'b1;
      end
      if (pre_cnt_reg != {CAS_PRE_W{1'b0}}) begin
        pre_cnt_reg <= pre_cnt_reg - 1'b1;
      end
      // grant regained: take the bus back
      if (!mastership_reg && granted) begin
        mastership_reg <= 1'b1;
      end
      // non-dram or dram transfer pending when grant went away
      if (lost && bg_sync_reg && !bg_prev_reg && any_open) begin
        if (nondram_busy && !dram_active) begin
          ras_hi_reg <= 1'b0;
          release_pend_reg <= 1'b1;
        end else if (dram_active) begin
          release_pend_reg <= 1'b1;
        end
      end
      if (release_pend_reg && !nondram_busy && !dram_active) begin
        mastership_reg <= 1'b0;
        ras_hi_reg <= 1'b0;
        release_pend_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (state_next == S_OFF) begin
            ras_hi_reg <= 1'b0;
            mastership_reg <= 1'b0;
          end else if (state_next == S_PRE) begin
            ras_hi_reg <= 1'b0;
            pre_cnt_reg <= PRE_LOAD;
          end
          if (req_go) begin
            cur_bank_reg <= req_bank;
            cur_write_reg <= req_write;
            cur_burst_reg <= req_ext_master;
            cur_row_reg <= req_row;
            cur_col_reg <= req_col;
            cur_wdata_reg <= req_wdata;
            cur_port_reg <= req_port;
            cas_mask_reg <= cas_for_port(req_port);
            new_page_reg <= !look_hit;
            transfer_size_code <= req_size;
          end
          if (req_go && state_next == S_T1) begin
            transfer_start_n <= 1'b0;
            mem_write_n <= ~req_write;
            addr_out <= look_hit ? req_col : req_row;
            ras_bank_reg <= (ras_bank_reg & {2{ras_hi_reg}}) |
              (2'h1 << req_bank);
            ras_hi_reg <= 1'b1;
          end
        end
        S_PRE: begin
          if (state_next == S_T1) begin
            transfer_start_n <= 1'b0;
            mem_write_n <= ~cur_write_reg;
            addr_out <= cur_row_reg;
            ras_bank_reg <= 2'h1 << cur_bank_reg;
            ras_hi_reg <= 1'b1;
          end
        end
        S_T1: begin
          addr_out <= cur_col_reg;
          // writes: data one clock after start, strobes that low phase
          data_oe <= cur_write_reg;
          data_out <= (cur_port_reg == 2'h1) ?
            {cur_wdata_reg[7:0], 24'h0} :
            (cur_port_reg == 2'h2) ?
            {cur_wdata_reg[15:0], 16'h0} : cur_wdata_reg;
          cas_en_reg <= 1'b1;
        end
        S_T2: begin
          ack_reg <= 1'b1;
        end
        S_T3: begin
          cas_en_reg <= 1'b0;
          new_page_reg <= 1'b0;
        end
        S_T4: begin
          data_oe <= 1'b0;
          gap_cnt_reg <= cas_pre_cycles + GAP_LOAD;
          if (cur_burst_reg) begin
            ras_hi_reg <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==================================================
  // tracker updates
  always @* begin
    open_set = (state_reg == S_T3) && !cur_burst_reg;
    close_all = (state_reg == S_PRE) ||
      (state_reg == S_T4 && cur_burst_reg) ||
      (state_reg == S_OFF) ||
      (release_pend_reg && !nondram_busy && !dram_active) ||
      (lost && bg_sync_reg && !bg_prev_reg && nondram_busy && !dram_active);
  end

  // ==================================================
  // falling-edge half-clock strobes
  always @(negedge ref_clk) begin
    if (rst) begin
      ras_fall_reg <= 2'h0;
      cas_fall_reg <= 4'h0;
    end else begin
      ras_fall_reg <= ras_bank_reg & {2{ras_hi_reg}};
      cas_fall_reg <= cas_en_reg ? cas_mask_reg : 4'h0;
    end
  end
endmodule

// [tb/fpm_page_props.sv]
// port checker for the fast-page page controller
// assumes binding onto fpm_page_ctrl, one ref_clk domain
`timescale 1ns/1ps
module fpm_page_props #(
  parameter ROW_W = 19,
  parameter CAS_PRE_W = 4
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // request side
  input wire req_valid,
  input wire req_write,
  input wire req_ext_master,
  input wire int_ack,
  input wire rd_valid,
  // arbitration
  input wire bus_lock_bit,
  input wire nondram_busy,
  input wire bus_grant_n,
  input wire bus_driven_n,
  // dram pins
  input wire addr_oe,
  input wire mem_write_n,
  input wire transfer_start_n,
  input wire [1:0] ras_n,
  input wire [3:0] cas_n,
  input wire data_oe
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ====
  // transfer phases
  property p_ack; $fell(transfer_start_n) |-> ##2 int_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ts; !transfer_start_n |=> transfer_start_n; endproperty
  a_ts: assert property (p_ts) else $error("start held");
  property p_dir; $fell(transfer_start_n) |-> mem_write_n != req_write;
  endproperty
  a_dir: assert property (p_dir) else $error("bad direction");
  property p_cas;
    int_ack |-> cas_n != 4'hf ##1 (cas_n == 4'hf && !int_ack);
  endproperty
  a_cas: assert property (p_cas) else $error("cas vs ack");
  property p_wd; !mem_write_n && cas_n != 4'hf |-> data_oe; endproperty
  a_wd: assert property (p_wd) else $error("write data off");
  property p_keep;
    int_ack && bus_lock_bit && !req_ext_master |=> ras_n != 2'h3;
  endproperty
  a_keep: assert property (p_keep) else $error("page closed");
  property p_gap; int_ack |=> transfer_start_n [*2]; endproperty
  a_gap: assert property (p_gap) else $error("hit too soon");
  property p_miss; $rose(ras_n[0]) && req_valid |-> ##[1:3] !ras_n[0];
  endproperty
  a_miss: assert property (p_miss) else $error("no reopen");
  property p_rd; int_ack && mem_write_n |-> ##2 rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("no read data");
  // ====
  // arbitration
  property p_lock;
    bus_lock_bit && $past(bus_lock_bit) && !bus_driven_n |=> !bus_driven_n;
  endproperty
  a_lock: assert property (p_lock) else $error("lock lost");
  property p_lose;
    $rose(bus_grant_n) && !bus_lock_bit && !nondram_busy |->
      ##[1:8] (bus_driven_n && ras_n == 2'h3 && !addr_oe);
  endproperty
  a_lose: assert property (p_lose) else $error("no release");
  property p_nd;
    $rose(bus_grant_n) && !bus_lock_bit && nondram_busy |->
      ##[1:4] (ras_n == 2'h3 && !bus_driven_n);
  endproperty
  a_nd: assert property (p_nd) else $error("no precharge");
  c_hit: cover property ($fell(transfer_start_n) && ras_n != 2'h3);
  c_miss: cover property ($rose(ras_n[0]) && req_valid);
  c_lock: cover property (bus_lock_bit && bus_grant_n && !bus_driven_n);
endmodule
bind fpm_page_ctrl fpm_page_props #(.ROW_W(ROW_W), .CAS_PRE_W(CAS_PRE_W))
  i_props (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
  .req_write(req_write), .req_ext_master(req_ext_master),
  .int_ack(int_ack), .rd_valid(rd_valid), .bus_lock_bit(bus_lock_bit),
  .nondram_busy(nondram_busy), .bus_grant_n(bus_grant_n),
  .bus_driven_n(bus_driven_n), .addr_oe(addr_oe),
  .mem_write_n(mem_write_n), .transfer_start_n(transfer_start_n),
  .ras_n(ras_n), .cas_n(cas_n), .data_oe(data_oe));

// [tb/dram_model.sv]
// behavioural fast-page dram, both banks, 16 columns kept
// assumes active-low strobes, column on the address during cas
`timescale 1ns/1ps
module dram_model (
  // clock
  input wire ref_clk,
  // dram pins
  input wire [1:0] ras_n,
  input wire [3:0] cas_n,
  input wire mem_write_n,
  input wire [27:9] addr_out,
  input wire [31:0] data_out,
  input wire data_oe,
  output wire [31:0] data_in
);
  reg [31:0] mem [0:15];
  reg [31:0] junk_reg = 32'h5a5a_c3c3;
  wire cas_on = cas_n != 4'hf && ras_n != 2'h3;
  // undriven bus flips each cycle so stale data never matches
  assign data_in = cas_on && mem_write_n ? mem[addr_out[12:9]] : junk_reg;
  always @(posedge ref_clk) begin
    junk_reg <= ~data_in;
    if (cas_on && !mem_write_n && data_oe)
      mem[addr_out[12:9]] <= data_out;
  end
endmodule

// [tb/tb_fast_page_dram_page_control.sv]
// self-checking bench for the fast-page page controller
// assumes hw/ on the include path, dram model and checker beside it
`timescale 1ns/1ps
`include "fpm_dram_regs.vh"
module tb_fast_page_dram_page_control;
  reg ref_clk = 1'h0;
  reg rst = 1'h1;
  reg req_valid = 1'h0, req_write = 1'h0, req_ext_master = 1'h0;
  reg req_bank = 1'h0, bus_lock_bit = 1'h1, nondram_busy = 1'h0;
  reg bus_grant_n = 1'h0;
  reg [18:0] req_row = 19'h0, req_col = 19'h0;
  reg [1:0] req_size = 2'h0, req_port = 2'h0;
  reg [31:0] req_wdata = 32'h0;
  reg [3:0] cas_pre_cycles = 4'h1;
  wire req_ready, rd_valid, int_ack, bus_driven_n, addr_oe, mem_write_n;
  wire transfer_start_n, data_oe;
  wire [31:0] rd_data, data_out, data_in;
  wire [27:9] addr_out;
  wire [1:0] transfer_size_code, ras_n;
  wire [3:0] cas_n;
  integer err_total = 0, n_compared = 0, lat;
  reg [27:9] st_addr;
  reg [1:0] st_size, ak_ras;
  reg [3:0] ak_cas;
  reg [31:0] ak_data, end_rd;
  reg st_ras, ak_oe, end_oe, end_rv;
  localparam [18:0] row_a = 19'h12a5, row_b = 19'h0c3a;
  fpm_page_ctrl i_dut (.ref_clk(ref_clk), .rst(rst),
    .req_valid(req_valid), .req_write(req_write),
    .req_ext_master(req_ext_master), .req_bank(req_bank),
    .req_row(req_row), .req_col(req_col), .req_size(req_size),
    .req_port(req_port), .req_wdata(req_wdata), .req_ready(req_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .int_ack(int_ack),
    .bus_lock_bit(bus_lock_bit), .cas_pre_cycles(cas_pre_cycles),
    .nondram_busy(nondram_busy), .bus_grant_n(bus_grant_n),
    .bus_driven_n(bus_driven_n), .addr_out(addr_out), .addr_oe(addr_oe),
    .mem_write_n(mem_write_n), .transfer_size_code(transfer_size_code),
    .transfer_start_n(transfer_start_n), .ras_n(ras_n), .cas_n(cas_n),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  dram_model i_mem (.ref_clk(ref_clk), .ras_n(ras_n), .cas_n(cas_n),
    .mem_write_n(mem_write_n), .addr_out(addr_out),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  always #5 ref_clk = ~ref_clk;
  // ====
  // helpers
  task finish_test;
    begin
      $display("compared %0d bad %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task bound(input integer n);
    if (n >= 12) begin
      err_total = err_total + 1;
      $display("BAD %0t wait ran out", $time);
      finish_test;
    end
  endtask
  // sample after the edge has settled, before the falling edge
  task tick;
    begin
      @(posedge ref_clk);
      #2;
    end
  endtask
  task wait_bd(input v);
    integer n;
    begin
      n = 0;
      while (bus_driven_n !== v && n < 12) begin
        tick;
        n = n + 1;
      end
      bound(n);
    end
  endtask
  task xfer(input w, input b, input [18:0] row, input [18:0] col,
    input [1:0] sz, input [1:0] pt, input ext, input [31:0] wd);
    begin
      @(posedge ref_clk);
      req_valid <= 1'h1;
      req_write <= w;
      req_bank <= b;
      req_row <= row;
      req_col <= col;
      req_size <= sz;
      req_port <= pt;
      req_ext_master <= ext;
      req_wdata <= wd;
      lat = 0;
      while (req_ready !== 1'h1 && lat < 12) begin
        tick;
        lat = lat + 1;
        if (transfer_start_n === 1'h0) begin
          st_addr = addr_out;
          st_size = transfer_size_code;
          st_ras = ras_n[b];
        end
      end
      bound(lat);
      ak_cas = cas_n;
      ak_data = data_out;
      ak_oe = data_oe;
      ak_ras = ras_n;
      @(posedge ref_clk);
      req_valid <= 1'h0;
      tick;
      end_oe = data_oe;
      end_rv = rd_valid;
      end_rd = rd_data;
    end
  endtask
  // ====
  // scenarios
  task t_write;
    begin
      xfer(1'h1, 1'h0, row_a, 19'h1, `SIZE_WORD, 2'h2, 1'h0, 32'h1e_c35a);
      cmp(lat, 3);
      cmp(st_addr, row_a);
      cmp(st_size, `SIZE_WORD);
      cmp(st_ras, 1'h1);
      cmp(ak_cas, 4'hc);
      cmp(ak_data[31:16], 16'hc35a);
      cmp(ak_oe, 1'h1);
      cmp(end_oe, 1'h0);
      cmp(ak_ras, 2'h2);
      // back to back: the gap is enforced by the controller
      xfer(1'h1, 1'h0, row_a, 19'h2, `SIZE_WORD, 2'h2, 1'h0, 32'h9e71);
      cmp(st_addr, 19'h2);
      cmp(st_ras, 1'h0);
      cmp(ak_data[31:16], 16'h9e71);
      repeat (6) @(posedge ref_clk);
      xfer(1'h0, 1'h0, row_a, 19'h2, `SIZE_BYTE, 2'h1, 1'h0, 32'h0);
      cmp(lat, 3);
      cmp(st_size, `SIZE_BYTE);
      cmp(ak_cas, 4'he);
      cmp(end_rv, 1'h1);
      cmp(end_rd[31:24], 8'h9e);
      $display("write and hit read done");
    end
  endtask
  task t_miss;
    integer i;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        repeat (6) @(posedge ref_clk);
        xfer(i[0], 1'h0, i ? row_a : row_b, 19'h3, `SIZE_BYTE, 2'h1,
          1'h0, 32'ha5);
        cmp(lat, 3 + `RAS_PRE_CYC);
        cmp(st_addr, i ? row_a : row_b);
        cmp(st_ras, 1'h1);
        cmp(st_size, `SIZE_BYTE);
      end
      repeat (6) @(posedge ref_clk);
      xfer(1'h0, 1'h1, row_b, 19'h2, `SIZE_LONG, 2'h0, 1'h0, 32'h0);
      cmp(lat, 3);
      cmp(ak_ras, 2'h0);
      xfer(1'h0, 1'h0, row_a, 19'h2, `SIZE_LONG, 2'h0, 1'h1, 32'h0);
      repeat (2) tick;
      // an external access closes every open page
      cmp(ras_n, 2'h3);
      $display("miss, other bank, external done");
    end
  endtask
  task t_arb;
    begin
      @(posedge ref_clk);
      bus_lock_bit <= 1'h0;
      bus_grant_n <= 1'h1;
      wait_bd(1'h1);
      cmp(ras_n, 2'h3);
      cmp(addr_oe, 1'h0);
      @(posedge ref_clk);
      bus_grant_n <= 1'h0;
      wait_bd(1'h0);
      xfer(1'h0, 1'h0, row_b, 19'h2, `SIZE_LONG, 2'h0, 1'h0, 32'h0);
      @(posedge ref_clk);
      bus_lock_bit <= 1'h1;
      bus_grant_n <= 1'h1;
      repeat (8) tick;
      cmp(bus_driven_n, 1'h0);
      cmp(ras_n, 2'h2);
      @(posedge ref_clk);
      bus_grant_n <= 1'h0;
      repeat (4) @(posedge ref_clk);
      bus_lock_bit <= 1'h0;
      nondram_busy <= 1'h1;
      bus_grant_n <= 1'h1;
      repeat (5) tick;
      cmp(ras_n, 2'h3);
      cmp(bus_driven_n, 1'h0);
      @(posedge ref_clk);
      nondram_busy <= 1'h0;
      wait_bd(1'h1);
      $display("arbitration done");
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    t_write;
    t_miss;
    t_arb;
    finish_test;
  end
endmodule
